//--- hw/ipvc_top.sv
// Purpose: interrupt pin function select, priority and vector supply
// Assumes: config port driven by synchronous load/move accesses
// Notes:   ack pin is open drain; vector read on second acknowledge cycle
// Functional notes
// - three interrupt methods chosen by configuration
// - pin assertions taken in any bus state
// - pin zero: service request or message waiting
// - controller request starts acknowledge sequence
// - open-drain acknowledge held through data and waits
// - 32-bit register, eight bits per input
// - input zero vector from bits 7..0
// - field zero 00 makes pin zero message
// - field two 00 selects request/acknowledge pins
// - inputs zero and one stay usable
// - register read/written at FF000004
// - resets to FF000000 with default pin roles
// - priority zero, one, two, three
// - vector indexes interrupt table entry
// - five idle states between acknowledge cycles
`timescale 1ns/1ps
module ipvc_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        cfg_sel_i,
  input  wire logic        cfg_write_i,
  input  wire logic [31:0] cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic             cfg_ack_o,
  output logic      [31:0] cfg_rdata_o,
  input  wire logic        direct_request_zero_b_i,
  input  wire logic        direct_request_one_i,
  input  wire logic        direct_request_two_i,
  input  wire logic        direct_request_three_b_i,
  output logic             ext_ack_out_o,
  output logic             ext_ack_oe_o,
  input  wire logic        ack_ready_i,
  input  wire logic [7:0]  ack_data_i,
  output logic             irq_valid_o,
  output logic      [7:0]  irq_vector_o,
  output logic      [1:0]  irq_source_o,
  output logic             irq_from_ctl_o,
  input  wire logic        irq_taken_i,
  output logic             agent_message_pending_o
);

  ipvc_pin_if pins ();

  logic [31:0]            interrupt_vector_config;
  logic [31:0]            next_cfg;
  logic [3:0]             pend;
  logic [3:0]             next_pend;
  logic [3:0]             clr_mask;
  logic [3:0]             enable;
  logic                   ctl_pend;
  logic                   next_ctl_pend;
  logic [7:0]             ctl_vec;
  logic                   ctl_done;
  logic                   ctl_mode;
  logic                   taken;
  logic [2:0]             gap_cnt;
  ipvc_pkg::ipvc_ack_st_t st;
  ipvc_pkg::ipvc_ack_st_t next_st;
  logic [1:0]             next_src;

  // field of input idx
  // byte field per input
  function automatic logic [7:0] field_of(input logic [31:0] cfg, input logic [1:0] idx);
    return cfg[{idx, 3'b000} +: ipvc_pkg::FIELD_W];
  endfunction

  // pins acting as direct inputs under a configuration
  // field zero selects message
  function automatic logic [3:0] direct_enable(input logic [31:0] cfg);
    logic dir2;
    dir2 = cfg[ipvc_pkg::FIELD2_LSB +: ipvc_pkg::FIELD_W] != ipvc_pkg::FIELD_ALT;
    return {dir2, dir2, 1'b1,
            cfg[ipvc_pkg::FIELD0_LSB +: ipvc_pkg::FIELD_W] != ipvc_pkg::FIELD_ALT};
  endfunction

  // lowest set bit index
  function automatic logic [1:0] first_set(input logic [3:0] v);
    if (v[0]) return 2'h0;
    else if (v[1]) return 2'h1;
    else if (v[2]) return 2'h2;
    else return 2'h3;
  endfunction

  // bits below index
  function automatic logic [3:0] below_mask(input logic [1:0] idx);
    return 4'((5'h01 << idx) - 5'h01);
  endfunction

  // pins normalised to active high and synchronised continuously
  assign pins.raw = {~direct_request_three_b_i, direct_request_two_i,
                     direct_request_one_i, ~direct_request_zero_b_i};

  ipvc_pin_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pins      (pins)
  );

  always_comb begin
    next_cfg = interrupt_vector_config;
    if (cfg_sel_i && cfg_write_i && cfg_addr_i == ipvc_pkg::CFG_ADDR)
      next_cfg = cfg_wdata_i;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) interrupt_vector_config <= ipvc_pkg::CFG_RESET;
    else          interrupt_vector_config <= next_cfg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h00000000;
    end else begin
      cfg_ack_o   <= cfg_sel_i;
      // unmapped reads return zero
      if (cfg_sel_i && !cfg_write_i && cfg_addr_i == ipvc_pkg::CFG_ADDR)
        cfg_rdata_o <= interrupt_vector_config;
      else
        cfg_rdata_o <= 32'h00000000;
    end
  end

  assign enable   = direct_enable(interrupt_vector_config);
  assign ctl_mode = interrupt_vector_config[ipvc_pkg::FIELD2_LSB +: ipvc_pkg::FIELD_W]
                    == ipvc_pkg::FIELD_ALT;
  assign taken    = irq_taken_i && irq_valid_o;
  assign clr_mask = (taken && !irq_from_ctl_o) ? 4'(5'h01 << irq_source_o) : 4'h0;

  // pending direct requests, set wins over clear
  always_comb begin
    next_pend     = ((pend & ~clr_mask) | (pins.rise & enable)) & enable;
    next_ctl_pend = (ctl_pend && !(taken && irq_from_ctl_o)) || ctl_done;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend     <= 4'h0;
      ctl_pend <= 1'b0;
    end else begin
      pend     <= next_pend;
      ctl_pend <= next_ctl_pend;
    end
  end

  assign next_src = first_set(next_pend);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_valid_o    <= 1'b0;
      irq_vector_o   <= 8'h00;
      irq_source_o   <= 2'h0;
      irq_from_ctl_o <= 1'b0;
    end else begin
      irq_valid_o    <= (|next_pend) || next_ctl_pend;
      irq_source_o   <= next_src;
      irq_from_ctl_o <= !(|next_pend) && next_ctl_pend;
      if (|next_pend)
        irq_vector_o <= field_of(next_cfg, next_src);
      else if (ctl_done)
        irq_vector_o <= ack_data_i;
      else if (next_ctl_pend)
        irq_vector_o <= ctl_vec;
      else
        irq_vector_o <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) agent_message_pending_o <= 1'b0;
    else          agent_message_pending_o <= pins.level[0] && !enable[0];
  end

  assign ctl_done = (st == ipvc_pkg::ACK2_DATA) && ack_ready_i;

  always_comb begin
    next_st = st;
    case (st)
      ipvc_pkg::ACK_IDLE:
        if (ctl_mode && pins.level[2] && !ctl_pend) next_st = ipvc_pkg::ACK1_ADDRESS;
      ipvc_pkg::ACK1_ADDRESS: next_st = ipvc_pkg::ACK1_DATA;
      ipvc_pkg::ACK1_DATA:
        if (ack_ready_i) next_st = ipvc_pkg::ACK_GAP;
      ipvc_pkg::ACK_GAP:
        if (gap_cnt == ipvc_pkg::GAP_LAST) next_st = ipvc_pkg::ACK2_ADDRESS;
      ipvc_pkg::ACK2_ADDRESS: next_st = ipvc_pkg::ACK2_DATA;
      ipvc_pkg::ACK2_DATA:
        if (ack_ready_i) next_st = ipvc_pkg::ACK_IDLE;
      default: next_st = ipvc_pkg::ACK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) st <= ipvc_pkg::ACK_IDLE;
    else          st <= next_st;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)                   gap_cnt <= 3'h0;
    else if (st == ipvc_pkg::ACK_GAP) gap_cnt <= gap_cnt + 3'h1;
    else                            gap_cnt <= 3'h0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)      ctl_vec <= 8'h00;
    else if (ctl_done) ctl_vec <= ack_data_i;
  end

  // open-drain acknowledge held through data and waits
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_ack_oe_o  <= 1'b0;
      ext_ack_out_o <= 1'b0;
    end else begin
      ext_ack_oe_o  <= next_st != ipvc_pkg::ACK_IDLE && next_st != ipvc_pkg::ACK_GAP;
      ext_ack_out_o <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  write_store_a: assert property (cfg_sel_i && cfg_write_i
    && cfg_addr_i == ipvc_pkg::CFG_ADDR |=> interrupt_vector_config == $past(cfg_wdata_i))
    else $error("config write not stored");

  read_back_a: assert property (cfg_sel_i && !cfg_write_i
    && cfg_addr_i == ipvc_pkg::CFG_ADDR
    |=> cfg_ack_o && cfg_rdata_o == $past(interrupt_vector_config))
    else $error("config read value wrong");

  priority_order_a: assert property (irq_valid_o && !irq_from_ctl_o
    |-> pend[irq_source_o] && (pend & below_mask(irq_source_o)) == 4'h0)
    else $error("lower priority input presented first");

  vector_field_a: assert property (irq_valid_o && !irq_from_ctl_o
    |-> irq_vector_o == interrupt_vector_config[{irq_source_o, 3'b000} +: 8])
    else $error("vector does not match field");

  msg_select_a: assert property ($past(interrupt_vector_config[7:0]) != 8'h00
    |-> !agent_message_pending_o)
    else $error("message flagged while pin zero is direct");

  mode_mask_a: assert property ($past(interrupt_vector_config[23:16]) == 8'h00
    |-> pend[3:2] == 2'b00)
    else $error("request/ack pins treated as direct inputs");

  ctl_start_a: assert property (st == ipvc_pkg::ACK_IDLE && ctl_mode && pins.level[2]
    && !ctl_pend |=> ext_ack_oe_o)
    else $error("controller request not acknowledged");

  ack_gap_a: assert property (st == ipvc_pkg::ACK1_DATA && ack_ready_i
    |=> !ext_ack_oe_o [*5] ##1 ext_ack_oe_o)
    else $error("idle gap between acknowledges not five");

  ack_hold_a: assert property (st == ipvc_pkg::ACK2_DATA && !ack_ready_i
    |=> ext_ack_oe_o && !ext_ack_out_o)
    else $error("acknowledge dropped during wait");

  unmapped_zero_a: assert property (cfg_sel_i && cfg_addr_i != ipvc_pkg::CFG_ADDR
    |=> cfg_ack_o && cfg_rdata_o == 32'h00000000
        && interrupt_vector_config == $past(interrupt_vector_config))
    else $error("unmapped access not answered with zero");

  msg_source_a: assert property (agent_message_pending_o
    |-> $past(pins.raw[0], 3))
    else $error("message flagged without pin zero asserted");

  direct_take_a: assert property ((pins.rise & enable) != 4'h0
    |=> irq_valid_o)
    else $error("direct request not presented");

  zero_vector_a: assert property (irq_valid_o && !irq_from_ctl_o && irq_source_o == 2'h0
    |-> irq_vector_o == interrupt_vector_config[7:0])
    else $error("input zero vector not from low field");

  ctl_vector_a: assert property (ctl_done && next_pend == 4'h0
    |=> irq_valid_o && irq_from_ctl_o && irq_vector_o == $past(ack_data_i))
    else $error("controller vector not presented");

  ctl_refuse_a: assert property (ctl_pend
    |-> st == ipvc_pkg::ACK_IDLE)
    else $error("acknowledge started while vector outstanding");

  ack_release_a: assert property (st == ipvc_pkg::ACK2_DATA && ack_ready_i
    |=> !ext_ack_oe_o)
    else $error("acknowledge held after second ready");

  direct_irq_c: cover property (irq_valid_o && !irq_from_ctl_o && irq_source_o == 2'h1);
  ctl_irq_c: cover property (ctl_done ##1 irq_valid_o && irq_from_ctl_o);
  message_c: cover property (agent_message_pending_o);
  ack_wait_c: cover property (st == ipvc_pkg::ACK1_DATA && !ack_ready_i);
  low_priority_c: cover property (irq_valid_o && !irq_from_ctl_o && irq_source_o == 2'h3);

endmodule // ipvc_top

//--- hw/ipvc_pkg.sv
// Purpose: shared constants and types of the interrupt pin and vector control block
// Assumes: one 100 MHz clock, active-low asynchronous reset
// Notes:   configuration word holds four 8-bit vector fields, one per direct input
package ipvc_pkg;

  localparam int unsigned NUM_PINS  = 4;
  localparam int unsigned FIELD_W   = 8;
  localparam int unsigned CFG_W     = 32;

  // configuration register address and value after initialization
  localparam logic [31:0] CFG_ADDR  = 32'hFF000004;
  localparam logic [31:0] CFG_RESET = 32'hFF000000;

  // field positions: input n occupies bits n*8+7 .. n*8
  localparam int unsigned FIELD0_LSB = 0;
  localparam int unsigned FIELD1_LSB = 8;
  localparam int unsigned FIELD2_LSB = 16;
  localparam int unsigned FIELD3_LSB = 24;

  // a zero in field zero or two switches pin zero, or pins two and three, to the alternate function
  localparam logic [7:0] FIELD_ALT = 8'h00;

  // idle states between the two acknowledge cycles
  localparam int unsigned GAP_IDLE_STATES = 5;
  localparam logic [2:0]  GAP_LAST        = 3'(GAP_IDLE_STATES - 1);

  // acknowledge sequencer, gray coded from ACK_IDLE through ACK2_DATA
  typedef enum logic [2:0] {
    ACK_IDLE     = 3'h0,
    ACK1_ADDRESS = 3'h1,
    ACK1_DATA    = 3'h3,
    ACK_GAP      = 3'h2,
    ACK2_ADDRESS = 3'h6,
    ACK2_DATA    = 3'h7
  } ipvc_ack_st_t;

endpackage

//--- hw/ipvc_pin_if.sv
// Purpose: carries interrupt pin levels between the top and the synchroniser
// Assumes: raw levels are already normalised to active high
// Notes:   rise marks a fresh assertion after a deasserted period
`timescale 1ns/1ps
interface ipvc_pin_if;
  logic [3:0] raw;
  logic [3:0] level;
  logic [3:0] rise;

  modport src (output raw, input level, input rise);
  modport sync (input raw, output level, output rise);
endinterface

//--- hw/ipvc_pin_sync.sv
// Purpose: two-stage synchroniser and assertion detector for the four pins
// Assumes: pins may be asynchronous to ref_clk_i
// Notes:   rise needs a deasserted sample followed by an asserted one
`timescale 1ns/1ps
module ipvc_pin_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  ipvc_pin_if.sync  pins
);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      logic meta;
      logic stable;
      logic prev;
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta   <= 1'b0;
          stable <= 1'b0;
          prev   <= 1'b0;
        end else begin
          meta   <= pins.raw[g];
          stable <= meta;
          prev   <= stable;
        end
      end
      assign pins.level[g] = stable;
      assign pins.rise[g]  = stable & ~prev;
    end
  endgenerate

  rise_edge_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (pins.rise & ~$past(pins.raw, 2)) == 4'h0)
    else $error("rise pulse without an asserted pin");

endmodule // ipvc_pin_sync

//--- dv/ipvc_ext_ctl_model.sv
// Purpose: external interrupt controller model on pins two and three
// Assumes: ack_oe_i high while the block pulls the pin low
// Notes:   ready after waits_i wait states; data idles inverted
`timescale 1ns/1ps
module ipvc_ext_ctl_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] vec_i,
  input  wire logic [1:0] waits_i,
  input  wire logic       ack_oe_i,
  output logic            req_o,
  output logic            ready_o,
  output logic      [7:0] data_o
);
  logic [2:0] cnt;
  logic       second;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) req_o <= 1'b0;
    else if (fire_i) req_o <= 1'b1;
    else if (ack_oe_i) req_o <= 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt    <= 3'h0;
      second <= 1'b0;
    end else begin
      cnt <= ack_oe_i ? cnt + 3'h1 : 3'h0;
      if (ready_o) second <= ~second;
    end
  end

  assign ready_o = ack_oe_i && (cnt == 3'h1 + 3'(waits_i));
  // vector only at the ready of the second cycle
  assign data_o  = (second && ready_o) ? vec_i : ~vec_i;
endmodule // ipvc_ext_ctl_model

//--- dv/test_interrupt_pin_vector_control.sv
// Purpose: self-checking bench for the interrupt pin and vector block
// Assumes: controller model on pins two and three
// Notes:   pins held at least two cycles each way around an assertion
`timescale 1ns/1ps
module test_interrupt_pin_vector_control;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        sel       = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] addr      = 32'h0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  act       = 4'h0;
  logic        taken     = 1'b0;
  logic        fire      = 1'b0;
  logic [7:0]  cvec      = 8'h0;
  logic [1:0]  cwait     = 2'h0;
  logic        ack, oe, aout, ready, req, valid, from_ctl, msg;
  logic [31:0] rdata;
  logic [7:0]  adata, vector;
  logic [1:0]  source;
  int          failures  = 0;
  int          n_checks  = 0;
  int          cycles    = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  ipvc_top uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cfg_sel_i(sel), .cfg_write_i(wr),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
    .direct_request_zero_b_i(~act[0]), .direct_request_one_i(act[1]),
    .direct_request_two_i(act[2] | req), .direct_request_three_b_i(~(act[3] | oe)),
    .ext_ack_out_o(aout), .ext_ack_oe_o(oe), .ack_ready_i(ready), .ack_data_i(adata),
    .irq_valid_o(valid), .irq_vector_o(vector), .irq_source_o(source),
    .irq_from_ctl_o(from_ctl), .irq_taken_i(taken), .agent_message_pending_o(msg)
  );

  ipvc_ext_ctl_model ctl (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .fire_i(fire), .vec_i(cvec),
    .waits_i(cwait), .ack_oe_i(oe), .req_o(req), .ready_o(ready), .data_o(adata)
  );

  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg(input logic w, input logic [31:0] a, d, exp_rd);
    sel = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    step();
    sel = 1'b0;
    chk("cfg_ack", 32'h1, {31'h0, ack});
    chk("cfg_rdata", exp_rd, rdata);
    step();
  endtask

  task automatic wait_valid(input int lim);
    for (int k = 0; k < lim && valid !== 1'b1; k++) step();
    chk("irq_valid", 32'h1, {31'h0, valid});
  endtask

  task automatic take;
    taken = 1'b1;
    step();
    taken = 1'b0;
    step();
  endtask

  task automatic s_reset;
    cfg(1'b0, ipvc_pkg::CFG_ADDR, 32'h0, ipvc_pkg::CFG_RESET);
    cfg(1'b1, 32'hFF000008, 32'h12345678, 32'h0);
    cfg(1'b0, 32'hFF000008, 32'h0, 32'h0);
    cfg(1'b0, ipvc_pkg::CFG_ADDR, 32'h0, ipvc_pkg::CFG_RESET);
    act[0] = 1'b1;
    step(6);
    chk("msg_pending", 32'h1, {31'h0, msg});
    chk("irq_valid", 32'h0, {31'h0, valid});
    act[0] = 1'b0;
    step(6);
    chk("msg_pending", 32'h0, {31'h0, msg});
  endtask

  task automatic s_direct;
    cfg(1'b1, ipvc_pkg::CFG_ADDR, 32'h44332211, 32'h0);
    cfg(1'b0, ipvc_pkg::CFG_ADDR, 32'h0, 32'h44332211);
    // all four asserted together for two cycles
    act = 4'hF;
    step(2);
    act = 4'h0;
    wait_valid(8);
    for (int i = 0; i < 4; i++) begin
      chk("irq_source", 32'(i), {30'h0, source});
      chk("irq_vector", 32'(17 * (i + 1)), {24'h0, vector});
      take();
    end
    chk("irq_valid", 32'h0, {31'h0, valid});
  endtask

  task automatic s_ctl;
    int hi;
    int gap;
    hi = 0;
    gap = 0;
    cfg(1'b1, ipvc_pkg::CFG_ADDR, 32'hFF002211, 32'h0);
    cvec = 8'h5A;
    cwait = 2'h2;
    fire = 1'b1;
    step();
    fire = 1'b0;
    for (int k = 0; k < 20 && oe !== 1'b1; k++) step();
    chk("ack_out", 32'h0, {31'h0, aout});
    while (oe === 1'b1 && hi < 20) begin
      step();
      hi++;
    end
    chk("ack_high", 32'd4, 32'(hi));
    while (oe !== 1'b1 && gap < 20) begin
      step();
      gap++;
    end
    chk("ack_gap", ipvc_pkg::GAP_IDLE_STATES, 32'(gap));
    wait_valid(20);
    chk("from_ctl", 32'h1, {31'h0, from_ctl});
    chk("irq_vector", 32'h5A, {24'h0, vector});
    take();
    step(4);
    chk("irq_valid", 32'h0, {31'h0, valid});
    // pin one pulsed while in controller mode
    act[1] = 1'b1;
    step(2);
    act[1] = 1'b0;
    wait_valid(8);
    chk("irq_source", 32'h1, {30'h0, source});
    chk("irq_vector", 32'h22, {24'h0, vector});
    take();
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    step(20);
    rst_b_i = 1'b1;
    s_reset();
    s_direct();
    s_ctl();
    final_report();
  end
endmodule // test_interrupt_pin_vector_control
